// [raidc_top.sv]
// Summary of operation
// - alarm compared with time after each update
// - alarm flag with enable raises request
// - top bits 11 make field match anything
// - second, minute, hour alarms at 01h/03h/05h
// - date alarm relocatable, default bank1 49h
// - month alarm relocatable, default bank1 4Ah
// - century relocatable, default bank1 48h
// - battery supply blocks all bus inputs
// - lockout held 62 ms after supply return
// - non-normal divider mode releases lockout at once
// - low battery with reset releases, initialises
// - invalid ram flag releases lockout at once
// - oscillator off on battery in listed cases
// - one low request line for three events
// - status read clears all flags
// - repeated event before service is lost
// - data-port writes ignored until validity bit read
// - four-bit rate code selects divider tap
// - divider field selects bank and chain mode
// - master reset keeps rate and divider fields
// - pending bit 244 us ahead, zero frozen
// - control B bits 6,5,4 are enables
// - update follows pending indication by 244 us
`timescale 1ns/1ps
`include "raidc_regs.svh"
module raidc_top #(
	parameter int TICK_DIV = `RAIDC_TICK_DIV,
	parameter int LOCK_CYCLES = `RAIDC_LOCK_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic io_sel,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic on_battery,
	input wire logic sys_above_bat,
	input wire logic bat_below_1v,
	input wire logic master_reset_indication,
	input wire logic supply_low,
	output logic irq_n,
	output logic osc_enable,
	output logic power_ctrl_enable,
	output logic bus_lockout
);
	raidc_pkg::raidc_top_st_t q;
	raidc_pkg::raidc_top_st_t n;
	raidc_tb_if tbi ();
	logic [4:0] pins_s;
	logic bat_s;
	logic above_s;
	logic low_s;
	logic mr_s;
	logic vlow_s;
	logic [1:0] bank;
	logic [7:0] rd_val;
	logic acc_ok;
	logic wr_idx;
	logic wr_dat;
	logic rd_dat;
	logic hit_all;
	logic fast_rel;

	// pins cross in from the supply monitor
	raidc_sync #(.W(5)) u_sync (
		.clk(clk),
		.srst(srst),
		.async_in({on_battery, sys_above_bat, bat_below_1v,
			master_reset_indication, supply_low}),
		.sync_out(pins_s)
	);
	assign {bat_s, above_s, low_s, mr_s, vlow_s} = pins_s;

	raidc_timebase #(.TICK_DIV(TICK_DIV)) u_tb (
		.clk(clk),
		.srst(srst),
		.tb(tbi.tb)
	);

	function automatic logic loc_hit(input logic [7:0] loc,
		input logic [1:0] bnk, input logic [6:0] idx);
		loc_hit = (bnk == {1'b0, loc[7]}) && (loc[6:0] == idx);
	endfunction

	function automatic logic alm_hit(input logic [7:0] alm,
		input logic [7:0] cur);
		alm_hit = (alm[7:6] == `RAIDC_DC_CODE) || (alm == cur);
	endfunction

	always_comb begin
		n = q;
		n.upd_d = tbi.update_pulse;
		if (q.dv == `RAIDC_DV_BANK1) bank = 2'h1;
		else if (q.dv == `RAIDC_DV_BANK2) bank = 2'h2;
		else bank = 2'h0;
		acc_ok = (q.lock == raidc_pkg::LOCK_OPEN);
		wr_idx = io_wr & (io_sel == `RAIDC_PORT_INDEX) & acc_ok;
		rd_dat = io_rd & (io_sel == `RAIDC_PORT_DATA) & acc_ok;
		wr_dat = io_wr & (io_sel == `RAIDC_PORT_DATA) & acc_ok & q.vrt_seen;
		hit_all = alm_hit(q.sec_alm, q.sec) & alm_hit(q.min_alm, q.min)
			& alm_hit(q.hr_alm, q.hr) & alm_hit(q.dom_alm, q.dom)
			& alm_hit(q.mon_alm, q.mon);
		fast_rel = ((q.dv != `RAIDC_DV_BANK0) && (q.dv != `RAIDC_DV_BANK1)
			&& (q.dv != `RAIDC_DV_BANK2)) || !q.ram_time_valid || (low_s && mr_s);

		if (q.index == `RAIDC_IDX_CTLA)
			rd_val = {tbi.update_pending, q.dv, q.rate};
		else if (q.index == `RAIDC_IDX_CTLB)
			rd_val = {q.ctlb[6:3], 1'b0, q.ctlb[2:0]};
		else if (q.index == `RAIDC_IDX_STAT)
			rd_val = {~q.irq_n, q.pf, q.af, q.uf, 4'h0};
		else if (q.index == `RAIDC_IDX_VALID)
			rd_val = {q.ram_time_valid, 7'h00};
		else if (q.index == `RAIDC_IDX_SEC) rd_val = q.sec;
		else if (q.index == `RAIDC_IDX_MIN) rd_val = q.min;
		else if (q.index == `RAIDC_IDX_HR) rd_val = q.hr;
		else if (q.index == `RAIDC_IDX_DOM) rd_val = q.dom;
		else if (q.index == `RAIDC_IDX_MON) rd_val = q.mon;
		else if (q.index == `RAIDC_IDX_SEC_ALM) rd_val = q.sec_alm;
		else if (q.index == `RAIDC_IDX_MIN_ALM) rd_val = q.min_alm;
		else if (q.index == `RAIDC_IDX_HR_ALM) rd_val = q.hr_alm;
		else if (bank == 2'h2 && q.index == `RAIDC_IDX_DOM_LOC)
			rd_val = q.dom_loc;
		else if (bank == 2'h2 && q.index == `RAIDC_IDX_MON_LOC)
			rd_val = q.mon_loc;
		else if (bank == 2'h2 && q.index == `RAIDC_IDX_CEN_LOC)
			rd_val = q.cen_loc;
		else if (loc_hit(q.dom_loc, bank, q.index)) rd_val = q.dom_alm;
		else if (loc_hit(q.mon_loc, bank, q.index)) rd_val = q.mon_alm;
		else if (loc_hit(q.cen_loc, bank, q.index)) rd_val = q.century;
		else rd_val = 8'h00;

		case (q.lock)
			raidc_pkg::LOCK_OPEN: begin
				if (bat_s) n.lock = raidc_pkg::LOCK_HELD;
			end
			raidc_pkg::LOCK_HELD: begin
				if (!bat_s && above_s) begin
					n.lock_cnt = 24'h00_0000;
					if (fast_rel) n.lock = raidc_pkg::LOCK_OPEN;
					else n.lock = raidc_pkg::LOCK_DELAY;
				end
			end
			raidc_pkg::LOCK_DELAY: begin
				if (bat_s) n.lock = raidc_pkg::LOCK_HELD;
				else if (q.lock_cnt == 24'(LOCK_CYCLES - 1))
					n.lock = raidc_pkg::LOCK_OPEN;
				else n.lock_cnt = q.lock_cnt + 24'h00_0001;
			end
			default: n.lock = raidc_pkg::LOCK_HELD;
		endcase

		if (q.lock == raidc_pkg::LOCK_HELD && !bat_s && above_s
			&& low_s && mr_s) begin
			n.sec = 8'h00;
			n.min = 8'h00;
			n.hr = 8'h00;
			n.dom = `RAIDC_RST_DOM;
			n.mon = `RAIDC_RST_MON;
			n.sec_alm = 8'h00;
			n.min_alm = 8'h00;
			n.hr_alm = 8'h00;
			n.ctlb[5:3] = 3'h0;
			n.pf = 1'b0;
			n.af = 1'b0;
			n.uf = 1'b0;
		end

		if (wr_idx) n.index = io_wdata[6:0];
		if (rd_dat) n.rdata = rd_val;
		else if (io_rd && acc_ok) n.rdata = {1'b0, q.index};

		if (wr_dat) begin
			if (q.index == `RAIDC_IDX_CTLA) begin
				n.dv = io_wdata[6:4];
				n.rate = io_wdata[3:0];
			end else if (q.index == `RAIDC_IDX_CTLB)
				n.ctlb = {io_wdata[7:4], io_wdata[2:0]};
			else if (q.index == `RAIDC_IDX_STAT ||
				q.index == `RAIDC_IDX_VALID)
				n.ctlb = q.ctlb;
			else if (q.index == `RAIDC_IDX_SEC) n.sec = io_wdata;
			else if (q.index == `RAIDC_IDX_MIN) n.min = io_wdata;
			else if (q.index == `RAIDC_IDX_HR) n.hr = io_wdata;
			else if (q.index == `RAIDC_IDX_DOM) n.dom = io_wdata;
			else if (q.index == `RAIDC_IDX_MON) n.mon = io_wdata;
			else if (q.index == `RAIDC_IDX_SEC_ALM) n.sec_alm = io_wdata;
			else if (q.index == `RAIDC_IDX_MIN_ALM) n.min_alm = io_wdata;
			else if (q.index == `RAIDC_IDX_HR_ALM) n.hr_alm = io_wdata;
			else if (bank == 2'h2 && q.index == `RAIDC_IDX_DOM_LOC)
				n.dom_loc = io_wdata;
			else if (bank == 2'h2 && q.index == `RAIDC_IDX_MON_LOC)
				n.mon_loc = io_wdata;
			else if (bank == 2'h2 && q.index == `RAIDC_IDX_CEN_LOC)
				n.cen_loc = io_wdata;
			else if (loc_hit(q.dom_loc, bank, q.index))
				n.dom_alm = io_wdata;
			else if (loc_hit(q.mon_loc, bank, q.index))
				n.mon_alm = io_wdata;
			else if (loc_hit(q.cen_loc, bank, q.index))
				n.century = io_wdata;
		end

		// binary calendar only, no month lengths
		if (tbi.update_pulse) begin
			if (q.sec < `RAIDC_SEC_LAST) n.sec = q.sec + 8'h01;
			else begin
				n.sec = 8'h00;
				if (q.min < `RAIDC_SEC_LAST) n.min = q.min + 8'h01;
				else begin
					n.min = 8'h00;
					if (q.hr < `RAIDC_HR_LAST) n.hr = q.hr + 8'h01;
					else begin
						n.hr = 8'h00;
						if (q.dom < `RAIDC_DOM_LAST) n.dom = q.dom + 8'h01;
						else begin
							n.dom = `RAIDC_RST_DOM;
							if (q.mon < `RAIDC_MON_LAST) n.mon = q.mon + 8'h01;
							else n.mon = `RAIDC_RST_MON;
						end
					end
				end
			end
		end

		if (rd_dat && q.index == `RAIDC_IDX_STAT) begin
			n.pf = 1'b0;
			n.af = 1'b0;
			n.uf = 1'b0;
		end
		// flags are single bits, no queue
		if (tbi.periodic_pulse) n.pf = 1'b1;
		if (tbi.update_pulse) n.uf = 1'b1;
		if (q.upd_d && hit_all) n.af = 1'b1;

		// validity read also unlocks writes
		if (rd_dat && q.index == `RAIDC_IDX_VALID) begin
			n.ram_time_valid = 1'b1;
			n.vrt_seen = 1'b1;
		end
		if (vlow_s) n.ram_time_valid = 1'b0;

		n.osc = !(bat_s && (q.dv == `RAIDC_DV_OFF0
			|| q.dv == `RAIDC_DV_OFF1 || !q.ram_time_valid));

		n.irq_n = !((n.ctlb[`RAIDC_B_PIE - 1] & n.pf)
			| (n.ctlb[`RAIDC_B_AIE - 1] & n.af)
			| (n.ctlb[`RAIDC_B_UIE - 1] & n.uf));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			q <= '0;
			q.dom <= `RAIDC_RST_DOM;
			q.mon <= `RAIDC_RST_MON;
			q.dom_alm <= `RAIDC_RST_DATE_ALM;
			q.mon_alm <= `RAIDC_RST_DATE_ALM;
			q.century <= `RAIDC_RST_CENTURY;
			q.dom_loc <= `RAIDC_RST_DOM_LOC;
			q.mon_loc <= `RAIDC_RST_MON_LOC;
			q.cen_loc <= `RAIDC_RST_CEN_LOC;
			q.dv <= `RAIDC_DV_BANK0;
			q.ram_time_valid <= 1'b1;
			q.lock <= raidc_pkg::LOCK_OPEN;
			q.osc <= 1'b1;
			q.irq_n <= 1'b1;
		end else q <= n;
	end

	assign tbi.run = q.osc;
	assign tbi.chain_clr = (q.dv[2:1] == `RAIDC_DV_CLR);
	assign tbi.freeze = q.ctlb[`RAIDC_B_SET - 1];
	assign tbi.rate = q.rate;
	assign io_rdata = q.rdata;
	assign irq_n = q.irq_n;
	assign osc_enable = q.osc;
	assign power_ctrl_enable = q.osc;
	assign bus_lockout = (q.lock != raidc_pkg::LOCK_OPEN);

	a_alarm_sets_flag: assert property (@(posedge clk) disable iff (srst)
		q.upd_d && hit_all |=> q.af) else $error("alarm flag not set");
	a_alarm_raises_irq: assert property (@(posedge clk) disable iff (srst)
		q.af && q.ctlb[`RAIDC_B_AIE - 1] |-> !irq_n)
		else $error("alarm request missing");
	a_dontcare_matches: assert property (@(posedge clk) disable iff (srst)
		q.upd_d && q.min_alm[7:6] == 2'b11 && q.sec_alm == q.sec
		&& q.hr_alm == q.hr && q.dom_alm[7:6] == 2'b11
		&& q.mon_alm[7:6] == 2'b11 |=> q.af)
		else $error("dont care not matching");
	a_battery_locks: assert property (@(posedge clk) disable iff (srst)
		bat_s |=> bus_lockout) else $error("no lockout on battery");
	a_locked_no_write: assert property (@(posedge clk) disable iff (srst)
		bus_lockout && !above_s |=> $stable(q.century) && $stable(q.index))
		else $error("write during lockout");
	a_delay_holds: assert property (@(posedge clk) disable iff (srst)
		q.lock == raidc_pkg::LOCK_DELAY && !bat_s
		&& q.lock_cnt < 24'(LOCK_CYCLES - 1) |=> bus_lockout)
		else $error("lockout released early");
	a_stat_read_clears: assert property (@(posedge clk) disable iff (srst)
		rd_dat && q.index == `RAIDC_IDX_STAT && !tbi.periodic_pulse
		&& !tbi.update_pulse && !(q.upd_d && hit_all)
		|=> !q.pf && !q.af && !q.uf) else $error("flags not cleared");
	a_write_needs_valid: assert property (@(posedge clk) disable iff (srst)
		!q.vrt_seen |=> $stable(q.dv) && $stable(q.rate))
		else $error("write before validity read");
	a_irq_released: assert property (@(posedge clk) disable iff (srst)
		!q.pf && !q.af && !q.uf |-> irq_n) else $error("request stuck low");
endmodule

// [raidc_regs.svh]
`ifndef RAIDC_REGS_SVH
`define RAIDC_REGS_SVH
`define RAIDC_PORT_INDEX 1'b0
`define RAIDC_PORT_DATA 1'b1
`define RAIDC_IDX_SEC 7'h00
`define RAIDC_IDX_SEC_ALM 7'h01
`define RAIDC_IDX_MIN 7'h02
`define RAIDC_IDX_MIN_ALM 7'h03
`define RAIDC_IDX_HR 7'h04
`define RAIDC_IDX_HR_ALM 7'h05
`define RAIDC_IDX_DOM 7'h07
`define RAIDC_IDX_MON 7'h08
`define RAIDC_IDX_CTLA 7'h0A
`define RAIDC_IDX_CTLB 7'h0B
`define RAIDC_IDX_STAT 7'h0C
`define RAIDC_IDX_VALID 7'h0D
`define RAIDC_IDX_CEN_LOC 7'h48
`define RAIDC_IDX_DOM_LOC 7'h49
`define RAIDC_IDX_MON_LOC 7'h4A
`define RAIDC_RST_CEN_LOC 8'hC8
`define RAIDC_RST_DOM_LOC 8'hC9
`define RAIDC_RST_MON_LOC 8'hCA
`define RAIDC_RST_DATE_ALM 8'hC0
`define RAIDC_RST_CENTURY 8'h00
`define RAIDC_RST_DOM 8'h01
`define RAIDC_RST_MON 8'h01
`define RAIDC_DC_CODE 2'b11
`define RAIDC_SEC_LAST 8'h3B
`define RAIDC_HR_LAST 8'h17
`define RAIDC_DOM_LAST 8'h1F
`define RAIDC_MON_LAST 8'h0C
`define RAIDC_B_SET 7
`define RAIDC_B_PIE 6
`define RAIDC_B_AIE 5
`define RAIDC_B_UIE 4
`define RAIDC_B_DM 2
`define RAIDC_B_HR24 1
`define RAIDC_B_DSE 0
`define RAIDC_DV_OFF0 3'h0
`define RAIDC_DV_OFF1 3'h1
`define RAIDC_DV_BANK0 3'h2
`define RAIDC_DV_BANK1 3'h3
`define RAIDC_DV_BANK2 3'h4
`define RAIDC_DV_CLR 2'h3
`define RAIDC_CLK_PERIOD_NS 5
`define RAIDC_CLK_HZ 200000000
`define RAIDC_TICK_HZ 32768
`define RAIDC_TICK_DIV (`RAIDC_CLK_HZ / `RAIDC_TICK_HZ)
`define RAIDC_LOCK_MIN_MS 62
`define RAIDC_LOCK_CYC ((`RAIDC_LOCK_MIN_MS * 1000000 + `RAIDC_CLK_PERIOD_NS - 1) / `RAIDC_CLK_PERIOD_NS)
`define RAIDC_UIP_US 244
`define RAIDC_UIP_TICKS ((`RAIDC_UIP_US * `RAIDC_TICK_HZ + 999999) / 1000000)
`define RAIDC_UIP_START (14'h3FFF - 14'(`RAIDC_UIP_TICKS - 1))
`endif

// [raidc_pkg.sv]
package raidc_pkg;
	typedef enum logic [1:0] {LOCK_OPEN, LOCK_HELD, LOCK_DELAY} raidc_lock_t;
	typedef struct packed {
		logic [12:0] presc;
		logic [14:0] chain;
		logic upd;
		logic per;
		logic pend;
	} raidc_tb_st_t;
	typedef struct packed {
		logic [6:0] index;
		logic [7:0] rdata;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr;
		logic [7:0] dom;
		logic [7:0] mon;
		logic [7:0] sec_alm;
		logic [7:0] min_alm;
		logic [7:0] hr_alm;
		logic [7:0] dom_alm;
		logic [7:0] mon_alm;
		logic [7:0] century;
		logic [7:0] dom_loc;
		logic [7:0] mon_loc;
		logic [7:0] cen_loc;
		logic [3:0] rate;
		logic [2:0] dv;
		logic [6:0] ctlb;
		logic pf;
		logic af;
		logic uf;
		logic ram_time_valid;
		logic vrt_seen;
		logic upd_d;
		raidc_lock_t lock;
		logic [23:0] lock_cnt;
		logic osc;
		logic irq_n;
	} raidc_top_st_t;
endpackage

// [raidc_tb_if.sv]
`timescale 1ns/1ps
interface raidc_tb_if;
	logic run;
	logic chain_clr;
	logic freeze;
	logic [3:0] rate;
	logic update_pulse;
	logic periodic_pulse;
	logic update_pending;
	modport ctl (output run, chain_clr, freeze, rate,
		input update_pulse, periodic_pulse, update_pending);
	modport tb (input run, chain_clr, freeze, rate,
		output update_pulse, periodic_pulse, update_pending);
endinterface

// [raidc_sync.sv]
`timescale 1ns/1ps
module raidc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} raidc_sync_st_t;
	raidc_sync_st_t q;
	raidc_sync_st_t n;
	always_comb begin
		n.s1 = async_in;
		n.s2 = q.s1;
	end
	always_ff @(posedge clk) begin
		if (srst) q <= '0;
		else q <= n;
	end
	assign sync_out = q.s2;
endmodule

// [raidc_timebase.sv]
`timescale 1ns/1ps
`include "raidc_regs.svh"
module raidc_timebase #(
	parameter int TICK_DIV = `RAIDC_TICK_DIV
) (
	input wire logic clk,
	input wire logic srst,
	raidc_tb_if.tb tb
);
	raidc_pkg::raidc_tb_st_t q;
	raidc_pkg::raidc_tb_st_t n;
	logic tick;
	logic tap_ok;
	logic [3:0] tap;
	logic [14:0] inc;

	always_comb begin
		n = q;
		n.upd = 1'b0;
		n.per = 1'b0;
		tick = 1'b0;
		tap_ok = 1'b1;
		inc = q.chain + 15'h0001;
		if (tb.rate == 4'h1) tap = 4'h6;
		else if (tb.rate == 4'h2) tap = 4'h7;
		else begin
			tap = tb.rate - 4'h2;
			tap_ok = (tb.rate != 4'h0);
		end
		// stopped oscillator freezes the whole chain
		if (tb.run) begin
			if (q.presc == 13'(TICK_DIV - 1)) begin
				n.presc = 13'h0000;
				tick = 1'b1;
			end else n.presc = q.presc + 13'h0001;
		end
		if (tb.chain_clr) begin
			n.chain = 15'h0000;
			n.presc = 13'h0000;
		end else if (tick) begin
			n.chain = inc;
			n.per = tap_ok & ~q.chain[tap] & inc[tap];
			n.upd = ~q.chain[14] & inc[14] & ~tb.freeze;
		end
		n.pend = ~tb.freeze & ~n.chain[14]
			& (n.chain[13:0] >= `RAIDC_UIP_START);
	end

	always_ff @(posedge clk) begin
		if (srst) q <= '0;
		else q <= n;
	end

	assign tb.update_pulse = q.upd;
	assign tb.periodic_pulse = q.per;
	assign tb.update_pending = q.pend;

	a_update_lead_pend: assert property (@(posedge clk) disable iff (srst)
		q.upd |-> $past(q.pend)) else $error("update without pending");
	a_freeze_no_pend: assert property (@(posedge clk) disable iff (srst)
		tb.freeze |=> !q.pend) else $error("pending while frozen");
	a_rate_none_quiet: assert property (@(posedge clk) disable iff (srst)
		tb.rate == 4'h0 |=> !q.per) else $error("periodic with rate none");
endmodule

// [raidc_host_model.sv]
`timescale 1ns/1ps
module raidc_host_model (
	input wire logic clk,
	output logic io_sel,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	output logic rd_done
);
	initial begin
		io_sel = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
		rd_done = 1'b0;
	end

	// one strobe cycle per access; data bus scrambled once released
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge clk);
		io_sel <= sel;
		io_wr <= 1'b1;
		io_wdata <= d;
		@(posedge clk);
		io_wr <= 1'b0;
		io_wdata <= ~d;
	endtask

	// answer is looked at two edges on, where it has surely landed
	task automatic rd();
		@(posedge clk);
		io_sel <= 1'b1;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		rd_done <= 1'b1;
		@(posedge clk);
		rd_done <= 1'b0;
	endtask
endmodule

// [raidc_testbench.sv]
`timescale 1ns/1ps
module testbench;
	localparam int LOCK = 20;
	logic clk, srst, io_sel, io_wr, io_rd, rd_done;
	logic [7:0] io_wdata, io_rdata, sec0, alm01, val;
	logic on_battery, sys_above_bat, bat_below_1v, mr_ind, supply_low;
	logic irq_n, osc_enable, power_ctrl_enable, bus_lockout;
	logic [15:0] exp_q[$];
	logic [15:0] mon_e;
	int n_errors, checks_done;
	integer seed = 32'hdb90_2bbf;

	raidc_host_model host_u (.clk(clk), .io_sel(io_sel), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .rd_done(rd_done));
	raidc_top #(.TICK_DIV(4), .LOCK_CYCLES(LOCK)) dut_u (.clk(clk),
		.srst(srst), .io_sel(io_sel), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .on_battery(on_battery),
		.sys_above_bat(sys_above_bat), .bat_below_1v(bat_below_1v),
		.master_reset_indication(mr_ind), .supply_low(supply_low),
		.irq_n(irq_n), .osc_enable(osc_enable),
		.power_ctrl_enable(power_ctrl_enable), .bus_lockout(bus_lockout));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e,
		input logic [7:0] m);
		checks_done++;
		if ((got & m) !== (e & m)) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, e);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic e);
		checks_done++;
		if (got !== e) begin
			n_errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		host_u.wr(1'b0, {1'b0, idx});
		host_u.wr(1'b1, d);
	endtask

	task automatic rd(input logic [6:0] idx, input logic [7:0] e,
		input logic [7:0] m);
		host_u.wr(1'b0, {1'b0, idx});
		exp_q.push_back({m, e});
		host_u.rd();
	endtask

	task automatic wait_irq(input int lim);
		int n = 0;
		while (irq_n !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
		cmp_bit(irq_n, 1'b0);
		if (irq_n !== 1'b0) begin
			report_and_stop();
		end
	endtask

	// battery spell, a refused write, then supply return
	task automatic supply_cycle(input logic slow, input logic osc);
		int n = 0;
		host_u.wr(1'b0, 8'h01);
		@(posedge clk);
		on_battery <= 1'b1;
		sys_above_bat <= 1'b0;
		while (bus_lockout !== 1'b1 && n < 10) begin
			@(negedge clk);
			n++;
		end
		cmp_bit(bus_lockout, 1'b1);
		if (bus_lockout !== 1'b1) begin
			report_and_stop();
		end
		host_u.wr(1'b1, 8'hee);
		@(negedge clk);
		cmp_bit(osc_enable, osc);
		cmp_bit(power_ctrl_enable, osc);
		@(posedge clk);
		on_battery <= 1'b0;
		sys_above_bat <= 1'b1;
		n = 0;
		while (bus_lockout !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		cmp_bit(bus_lockout, 1'b0);
		if (bus_lockout !== 1'b0) begin
			report_and_stop();
		end
		cmp_bit(slow ? (n >= LOCK && n < 2 * LOCK) : (n < LOCK / 2),
			1'b1);
	endtask

	// one note per read, taken off as the answer shows
	always @(negedge clk) begin
		if (rd_done === 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("mismatch at %0t got %h exp %h", $time, io_rdata, 0);
			end else begin
				mon_e = exp_q.pop_front();
				cmp_byte(io_rdata, mon_e[7:0], mon_e[15:8]);
			end
		end
	end

	initial begin
		srst = 1'b1;
		on_battery = 1'b0;
		sys_above_bat = 1'b1;
		bat_below_1v = 1'b0;
		mr_ind = 1'b0;
		supply_low = 1'b0;
		n_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		wr(7'h01, 8'h5a);
		rd(7'h01, 8'h00, 8'hff);
		rd(7'h0d, 8'h80, 8'hff);
		for (int i = 1; i < 6; i += 2) begin
			val = 8'($random(seed));
			wr(7'(i), val);
			rd(7'(i), val, 8'hff);
			if (i == 1) begin
				alm01 = val;
			end
		end
		wr(7'h0a, 8'h40);
		rd(7'h48, 8'hc8, 8'hff);
		rd(7'h49, 8'hc9, 8'hff);
		rd(7'h4a, 8'hca, 8'hff);
		wr(7'h0a, 8'h30);
		rd(7'h0a, 8'h30, 8'h7f);
		rd(7'h48, 8'h00, 8'hff);
		rd(7'h49, 8'hc0, 8'hff);
		rd(7'h4a, 8'hc0, 8'hff);
		val = 8'($random(seed));
		wr(7'h48, val);
		rd(7'h48, val, 8'hff);
		wr(7'h0a, 8'h20);
		rd(7'h49, 8'h00, 8'hff);
		rd(7'h20, 8'h00, 8'hff);
		wr(7'h0a, 8'h23);
		wr(7'h0b, 8'h40);
		wait_irq(200);
		rd(7'h0c, 8'hc0, 8'hff);
		wr(7'h0a, 8'h20);
		wr(7'h0b, 8'h00);
		rd(7'h0c, 8'h00, 8'h00);
		rd(7'h0c, 8'h00, 8'hff);
		supply_cycle(1'b1, 1'b1);
		rd(7'h01, alm01, 8'hff);
		wr(7'h0a, 8'h00);
		supply_cycle(1'b0, 1'b0);
		rd(7'h01, alm01, 8'hff);
		wr(7'h0a, 8'h20);
		@(posedge clk);
		supply_low <= 1'b1;
		repeat (4) @(posedge clk);
		supply_low <= 1'b0;
		repeat (4) @(posedge clk);
		supply_cycle(1'b0, 1'b0);
		rd(7'h0d, 8'h00, 8'h00);
		rd(7'h0d, 8'h80, 8'hff);
		@(posedge clk);
		bat_below_1v <= 1'b1;
		mr_ind <= 1'b1;
		supply_cycle(1'b0, 1'b1);
		@(posedge clk);
		bat_below_1v <= 1'b0;
		mr_ind <= 1'b0;
		rd(7'h01, 8'h00, 8'hff);
		rd(7'h0a, 8'h20, 8'h7f);
		wr(7'h0b, 8'h80);
		rd(7'h0a, 8'h20, 8'hff);
		// chain restart so the first update lands at a known point
		wr(7'h0a, 8'h60);
		wr(7'h0a, 8'h20);
		sec0 = 8'($unsigned($random(seed)) % 58);
		wr(7'h00, sec0);
		wr(7'h02, 8'h11);
		wr(7'h01, sec0 + 8'h01);
		wr(7'h03, 8'hc5);
		wr(7'h05, 8'h00);
		rd(7'h0b, 8'h80, 8'hff);
		wr(7'h0b, 8'h30);
		wait_irq(70000);
		rd(7'h0c, 8'hb0, 8'hff);
		@(negedge clk);
		cmp_bit(irq_n, 1'b1);
		rd(7'h00, sec0 + 8'h01, 8'hff);
		rd(7'h02, 8'h11, 8'hff);
		repeat (4) @(negedge clk);
		report_and_stop();
	end
endmodule
